// >>> design/led_serial_ctrl.sv
`timescale 1ns/100ps
// serial target, mode control, gain, dimming and ambient light logic
module led_serial_ctrl
    import led_ctrl_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h2A, // arbitrary value
    parameter int DLY0 = GAIN_DLY0_CYC,
    parameter int DLY1 = GAIN_DLY1_CYC,
    parameter int DLY2 = GAIN_DLY2_CYC,
    parameter int SINKS = 8
) (
    input wire logic clk, // core clock
    input wire logic rst_n, // async reset, active low
    input wire logic scl, // serial clock from master
    input wire logic sda_in, // serial data pin level
    output logic sda_out, // serial data drive value
    output logic sda_oe, // serial data drive enable
    input wire logic hw_enable_reset_pin, // enable pin, low is shutdown
    input wire logic pwm_in, // dimming input pin
    input wire logic [SINKS-1:0] headroom_low, // per-sink headroom comparators
    input wire logic [7:0] als_level, // ambient level from converter
    output logic int_out, // interrupt drive value
    output logic int_oe, // interrupt drive enable
    output logic [SINKS-1:0] sink_on, // current sink enables
    output logic pump_gain_high, // 3/2 gain selected
    output led_ctrl_pkg::power_mode_e power_mode, // device mode
    output logic bus_busy, // bus occupied
    output logic [2:0] als_zone, // ambient region 0..4
    output logic [7:0] als_bright // current code of region
);
    import led_ctrl_pkg::*;

    logic rst_ff;
    logic rst_sync_n;
    logic hw_en;
    logic scl_s;
    logic sda_s;
    logic sda_prev;
    logic pwm_s;
    logic [SINKS-1:0] head_s;
    logic start_cond;
    logic stop_cond;
    bus_state_e bus_state;
    bus_state_e next_bus_state;
    logic eng_run;
    // link-side state
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [1:0] byte_idx;
    logic matched;
    logic rd_dir;
    logic nack;
    logic [7:0] reg_addr;
    logic [7:0] wr_data;
    logic wr_tgl;
    logic [7:0] rx_byte;
    // core-side register state
    logic wr_tgl_s;
    logic wr_tgl_d;
    logic wr_pulse;
    logic [7:0] sink_en;
    logic [7:0] cfg;
    logic [7:0] opts;
    logic [7:0] bound [4];
    logic [7:0] bright [5];
    logic [2:0] zone_now;
    logic zone_seen;
    logic int_flag;
    logic gain_low;
    logic gain_sel;
    logic pwm_pass;

    // reset release through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_ff <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_ff <= 1'b1;
            rst_sync_n <= rst_ff;
        end
    end

    // pin synchronisers
    sync2 #(.W(4)) u_pins (
        .clk(clk),
        .rst_n(rst_sync_n),
        .d({hw_enable_reset_pin, scl, sda_in, pwm_in}),
        .q({hw_en, scl_s, sda_s, pwm_s})
    );

    sync2 #(.W(SINKS + 1)) u_head (
        .clk(clk),
        .rst_n(rst_sync_n),
        .d({headroom_low, wr_tgl}),
        .q({head_s, wr_tgl_s})
    );

    // data edges while clock high mark start and stop
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sda_prev <= 1'b1;
        end else begin
            sda_prev <= sda_s;
        end
    end

    assign start_cond = scl_s && sda_prev && !sda_s;
    assign stop_cond = scl_s && !sda_prev && sda_s;

    // bus occupancy; a repeated start restarts the frame
    always_comb begin
        next_bus_state = bus_state;
        case (bus_state)
            BUS_FREE: begin
                if (start_cond) begin
                    next_bus_state = BUS_START;
                end
            end
            BUS_START: begin
                if (stop_cond) begin
                    next_bus_state = BUS_FREE;
                end else if (!scl_s) begin
                    next_bus_state = BUS_BUSY;
                end
            end
            BUS_BUSY: begin
                if (stop_cond) begin
                    next_bus_state = BUS_FREE;
                end else if (start_cond) begin
                    next_bus_state = BUS_START;
                end
            end
            default: next_bus_state = BUS_FREE;
        endcase
        if (!hw_en) begin
            next_bus_state = BUS_FREE;
        end
    end

    // bus state, busy flag and the link engine release
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bus_state <= BUS_FREE;
            bus_busy <= 1'b0;
            eng_run <= 1'b0;
        end else begin
            bus_state <= next_bus_state;
            bus_busy <= next_bus_state != BUS_FREE;
            eng_run <= next_bus_state == BUS_BUSY;
        end
    end

    assign rx_byte = shift;

    // bit counter and shift register on rising serial clock
    always_ff @(posedge scl or negedge eng_run) begin
        if (!eng_run) begin
            bit_cnt <= '0;
            shift <= '0;
            byte_idx <= '0;
            nack <= 1'b0;
        end else if (bit_cnt < BITS_PER_BYTE) begin
            shift <= {shift[6:0], sda_in};
            bit_cnt <= bit_cnt + 1'b1;
        end else begin
            bit_cnt <= '0;
            if (byte_idx != 2'd3) begin
                byte_idx <= byte_idx + 1'b1;
            end
            if (rd_dir && matched && byte_idx != 2'd0 && sda_in) begin
                nack <= 1'b1;
            end
        end
    end

    // address match and direction, cleared by every start
    always_ff @(negedge scl or negedge eng_run) begin
        if (!eng_run) begin
            matched <= 1'b0;
            rd_dir <= 1'b0;
        end else if (bit_cnt == BITS_PER_BYTE && byte_idx == 2'd0) begin
            matched <= rx_byte[7:1] == DEV_ADDR;
            rd_dir <= rx_byte[0];
        end
    end

    // register select and data capture, kept across frames
    always_ff @(negedge scl or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reg_addr <= '0;
            wr_data <= '0;
            wr_tgl <= 1'b0;
        end else if (eng_run && matched && !rd_dir && bit_cnt == BITS_PER_BYTE) begin
            if (byte_idx == 2'd1) begin
                reg_addr <= rx_byte;
            end else if (byte_idx != 2'd0) begin
                wr_data <= rx_byte;
                wr_tgl <= !wr_tgl;
            end
        end
    end

    // data line drive on falling serial clock
    always_ff @(negedge scl or negedge eng_run) begin
        if (!eng_run) begin
            sda_oe <= 1'b0;
        end else if (bit_cnt == BITS_PER_BYTE) begin
            if (byte_idx == 2'd0) begin
                sda_oe <= rx_byte[7:1] == DEV_ADDR;
            end else if (matched && !rd_dir) begin
                sda_oe <= 1'b1;
            end else begin
                sda_oe <= 1'b0;
            end
        end else if (matched && rd_dir && byte_idx != 2'd0 && !nack) begin
            sda_oe <= !wr_data[3'(7 - bit_cnt)]; // last written byte reads back
        end else begin
            sda_oe <= 1'b0;
        end
    end

    assign sda_out = 1'b0;
    assign int_out = 1'b0;

    // write event crossing into the core domain
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wr_tgl_d <= 1'b0;
        end else begin
            wr_tgl_d <= wr_tgl_s;
        end
    end

    assign wr_pulse = (wr_tgl_s != wr_tgl_d) && hw_en;

    // control registers, cleared while the enable pin is low
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sink_en <= RST_SINK_EN;
            cfg <= RST_CONFIG;
            opts <= RST_OPTIONS;
        end else if (!hw_en) begin
            sink_en <= RST_SINK_EN;
            cfg <= RST_CONFIG;
            opts <= RST_OPTIONS;
        end else if (wr_pulse) begin
            case (reg_addr)
                ADDR_SINK_EN: sink_en <= wr_data;
                ADDR_CONFIG: cfg <= wr_data;
                ADDR_OPTIONS: opts <= wr_data;
                default: ;
            endcase
        end
    end

    // ambient trip points and region current codes
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            for (int i = 0; i < 4; i++) begin
                bound[i] <= RST_BOUNDS[i*8 +: 8];
            end
            for (int i = 0; i < 5; i++) begin
                bright[i] <= RST_BRIGHTS[i*8 +: 8];
            end
        end else if (!hw_en) begin
            for (int i = 0; i < 4; i++) begin
                bound[i] <= RST_BOUNDS[i*8 +: 8];
            end
            for (int i = 0; i < 5; i++) begin
                bright[i] <= RST_BRIGHTS[i*8 +: 8];
            end
        end else if (wr_pulse) begin
            for (int i = 0; i < 4; i++) begin
                if (reg_addr == ADDR_BOUND0 + 8'(i)) begin
                    bound[i] <= wr_data;
                end
            end
            for (int i = 0; i < 5; i++) begin
                if (reg_addr == ADDR_BRIGHT0 + 8'(i)) begin
                    bright[i] <= wr_data;
                end
            end
        end
    end

    // region = number of trip points below the level
    always_comb begin
        zone_now = 3'h0;
        for (int i = 0; i < 4; i++) begin
            if (als_level > bound[i]) begin
                zone_now = zone_now + 3'h1;
            end
        end
    end

    // region and its current code
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            als_zone <= 3'h0;
            als_bright <= 8'h00;
            zone_seen <= 1'b0;
        end else if (!hw_en) begin
            als_zone <= 3'h0;
            als_bright <= 8'h00;
            zone_seen <= 1'b0;
        end else begin
            als_zone <= zone_now;
            als_bright <= bright[zone_now];
            zone_seen <= 1'b1;
        end
    end

    // region change raises interrupt; a write clears it, a new change wins
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            int_flag <= 1'b0;
        end else if (!hw_en) begin
            int_flag <= 1'b0;
        end else if (zone_seen && zone_now != als_zone) begin
            int_flag <= 1'b1;
        end else if (wr_pulse) begin
            int_flag <= 1'b0;
        end
    end

    assign int_oe = int_flag;

    // headroom from enabled sinks only
    assign gain_low = |(head_s & sink_en[SINKS-1:0]);

    gain_filter #(.DLY0(DLY0), .DLY1(DLY1), .DLY2(DLY2)) u_gain (
        .clk(clk),
        .rst_n(rst_sync_n),
        .reeval(wr_pulse || !hw_en),
        .low(gain_low),
        .sel(opts[OPT_GAIN_LO +: 2]),
        .gain_high(gain_sel)
    );

    assign pump_gain_high = gain_sel;

    // dimming input gate with selectable polarity
    assign pwm_pass = !cfg[CFG_PWM_EN] || (pwm_s ^ cfg[CFG_PWM_POL]);

    // mode and sink outputs
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            power_mode <= MODE_SHUTDOWN;
            sink_on <= '0;
        end else if (!hw_en) begin
            power_mode <= MODE_SHUTDOWN;
            sink_on <= '0;
        end else if (sink_en == 8'h00) begin
            power_mode <= MODE_STANDBY;
            sink_on <= '0;
        end else begin
            power_mode <= MODE_ACTIVE;
            sink_on <= pwm_pass ? sink_en[SINKS-1:0] : '0;
        end
    end
endmodule

// >>> design/led_ctrl_pkg.sv
package led_ctrl_pkg;
    localparam int CLK_MHZ = 250;
    // internal register addresses
    localparam logic [7:0] ADDR_SINK_EN = 8'h10;
    localparam logic [7:0] ADDR_CONFIG = 8'h20;
    localparam logic [7:0] ADDR_OPTIONS = 8'h30;
    localparam logic [7:0] ADDR_BOUND0 = 8'h60;
    localparam logic [7:0] ADDR_BRIGHT0 = 8'h70;
    // reset values
    localparam logic [7:0] RST_SINK_EN = 8'h00;
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RST_OPTIONS = 8'h00;
    localparam logic [31:0] RST_BOUNDS = 32'hCC99_6633;
    localparam logic [39:0] RST_BRIGHTS = 40'hFF_E6CC_B699;
    // field positions
    localparam int CFG_PWM_EN = 0;
    localparam int CFG_PWM_POL = 1;
    localparam int OPT_GAIN_LO = 0;
    // serial framing
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // gain filter minimum times and derived cycle counts
    localparam int GAIN_DLY0_US = 3000;
    localparam int GAIN_DLY1_US = 800;
    localparam int GAIN_DLY2_US = 20;
    localparam int GAIN_DLY0_CYC = GAIN_DLY0_US * CLK_MHZ;
    localparam int GAIN_DLY1_CYC = GAIN_DLY1_US * CLK_MHZ;
    localparam int GAIN_DLY2_CYC = GAIN_DLY2_US * CLK_MHZ;
    localparam int GAIN_CNT_W = 20;
    // device power modes
    typedef enum logic [2:0] {
        MODE_SHUTDOWN = 3'b001,
        MODE_STANDBY = 3'b010,
        MODE_ACTIVE = 3'b100
    } power_mode_e;
    // bus occupancy tracking
    typedef enum logic [2:0] {
        BUS_FREE = 3'b001,
        BUS_START = 3'b010,
        BUS_BUSY = 3'b100
    } bus_state_e;
endpackage

// >>> design/sync2.sv
`timescale 1ns/100ps
// two-flop synchroniser for levels from another domain
module sync2 #(
    parameter int W = 1
) (
    input wire logic clk, // destination clock
    input wire logic rst_n, // async reset, active low
    input wire logic [W-1:0] d, // asynchronous level
    output logic [W-1:0] q // synchronised level
);
    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// >>> design/gain_filter.sv
`timescale 1ns/100ps
// pump gain selection with a programmable dip filter
module gain_filter
    import led_ctrl_pkg::*;
#(
    parameter int DLY0 = GAIN_DLY0_CYC,
    parameter int DLY1 = GAIN_DLY1_CYC,
    parameter int DLY2 = GAIN_DLY2_CYC
) (
    input wire logic clk, // core clock
    input wire logic rst_n, // async reset, active low
    input wire logic reeval, // pulse: drop back to pass mode and decide again
    input wire logic low, // an enabled sink is short of headroom
    input wire logic [1:0] sel, // filter delay code
    output logic gain_high // 1: 3/2 gain, 0: pass mode
);
    logic [GAIN_CNT_W-1:0] cnt;
    logic [GAIN_CNT_W-1:0] limit;

    // delay code decode, unused code falls back to the longest
    always_comb begin
        case (sel)
            2'b01: limit = GAIN_CNT_W'(DLY1);
            2'b10: limit = GAIN_CNT_W'(DLY2);
            default: limit = GAIN_CNT_W'(DLY0);
        endcase
    end

    // dips shorter than the limit restart the count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
        end else if (reeval || !low || gain_high) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    // gain latches high and stays until reeval (a write or the enable pin low)
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gain_high <= 1'b0;
        end else if (reeval) begin
            gain_high <= 1'b0;
        end else if (low && cnt >= limit - 1'b1) begin
            gain_high <= 1'b1;
        end
    end
endmodule

// >>> test/led_serial_ctrl_sva.sv
`timescale 1ns/100ps
// pin-level checks of the serial led controller
module led_serial_ctrl_sva
    import led_ctrl_pkg::*;
#(
    parameter int DLY2 = GAIN_DLY2_CYC,
    parameter int SINKS = 8
) (
    input wire logic clk, // core clock
    input wire logic rst_n, // reset, active low
    input wire logic scl, // serial clock
    input wire logic sda_in, // data wire level
    input wire logic sda_out, // data drive value
    input wire logic sda_oe, // data pull enable
    input wire logic hw_enable_reset_pin, // enable pin
    input wire logic [SINKS-1:0] headroom_low, // headroom flags
    input wire logic int_out, // interrupt drive value
    input wire logic int_oe, // interrupt pull enable
    input wire logic [SINKS-1:0] sink_on, // sink enables
    input wire logic pump_gain_high, // pump gain
    input wire led_ctrl_pkg::power_mode_e power_mode, // device mode
    input wire logic bus_busy, // bus occupied
    input wire logic [2:0] als_zone // ambient region
);
    int unsigned low_run;
    // length of the current run of any sink short of headroom
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_run <= 0;
        end else if (|headroom_low) begin
            low_run <= low_run + 1;
        end else begin
            low_run <= 0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_open_drain: assert property (!sda_out && !int_out)
        else $error("open-drain drive value is high");
    chk_shutdown_off: assert property ((!hw_enable_reset_pin) [*6] |->
        power_mode == MODE_SHUTDOWN && sink_on == '0 && !pump_gain_high && !int_oe && !bus_busy)
        else $error("outputs alive with enable pin low");
    chk_standby_dark: assert property ((power_mode == MODE_STANDBY) [*3] |-> sink_on == '0)
        else $error("sink on in standby");
    chk_active_mode: assert property (sink_on != '0 |-> power_mode == MODE_ACTIVE)
        else $error("sink on outside active mode");
    chk_busy_start: assert property (hw_enable_reset_pin [*8] ##0
        (scl && $past(scl) && $fell(sda_in)) |-> ##[1:6] bus_busy)
        else $error("start not seen");
    chk_free_stop: assert property (scl && $past(scl) && $rose(sda_in) |-> ##[1:6] !bus_busy)
        else $error("bus still busy after stop");
    chk_ack_steady: assert property (hw_enable_reset_pin && $past(hw_enable_reset_pin, 4)
        && scl && $past(scl) |-> $stable(sda_oe))
        else $error("data drive changed with clock high");
    chk_gain_filter: assert property ($rose(pump_gain_high) |-> low_run >= DLY2)
        else $error("gain rose without a long enough dip");
    chk_zone_irq: assert property (hw_enable_reset_pin [*6] ##0 $changed(als_zone)
        |-> ##[0:2] int_oe)
        else $error("region change without interrupt");
    chk_zone_range: assert property (als_zone <= 3'h4)
        else $error("region out of range");
    cover property ($rose(bus_busy));
    cover property ($rose(sda_oe));
    cover property ($rose(int_oe));
    cover property ($rose(pump_gain_high));
endmodule
bind led_serial_ctrl led_serial_ctrl_sva #(.DLY2(DLY2), .SINKS(SINKS)) i_led_serial_ctrl_sva (
    .clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .hw_enable_reset_pin(hw_enable_reset_pin), .headroom_low(headroom_low),
    .int_out(int_out), .int_oe(int_oe), .sink_on(sink_on), .pump_gain_high(pump_gain_high),
    .power_mode(power_mode), .bus_busy(bus_busy), .als_zone(als_zone));

// >>> test/bus_host_model.sv
`timescale 1ns/100ps
// two-wire bus master: makes the clock, pulls data low or lets the pull-up raise it
module bus_host_model (
    input wire logic sda, // resolved data wire
    output logic scl, // serial clock, still outside frames
    output logic pull_low // master pulls data low
);
    initial begin
        scl = 1'b1;
        pull_low = 1'b0;
    end
    // start or repeated start: data falls while the clock is high
    task automatic start();
        #0.7;
        pull_low = 1'b0;
        #5; // data settles more than one core clock before the clock rises
        scl = 1'b1;
        #20;
        pull_low = 1'b1;
        #20;
        scl = 1'b0;
        #1000;
    endtask
    // one slot: data set while the clock is low, held through the high phase
    task automatic slot(input logic b, output logic s);
        pull_low = !b;
        #5; // setup longer than a core clock, so no false start or stop
        scl = 1'b1;
        #6;
        s = sda;
        scl = 1'b0;
        #1;
    endtask
    // eight bits msb first, then a released acknowledge slot
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            slot(d[i], s);
        end
        slot(1'b1, s);
        ack = !s;
    endtask
    // read eight bits, then leave the ninth slot released (no acknowledge)
    task automatic read_byte(output logic [7:0] d, output logic low9);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            slot(1'b1, s);
            d[i] = s;
        end
        slot(1'b1, s);
        low9 = !s;
    endtask
    // stop: data rises while the clock is high
    task automatic stop();
        pull_low = 1'b1;
        #5; // low level seen before the clock rises
        scl = 1'b1;
        #20;
        pull_low = 1'b0;
        #40;
    endtask
endmodule

// >>> test/test_led_serial_ctrl.sv
`timescale 1ns/100ps
// bench with a register reference model, host model on the wire
module test_led_serial_ctrl;
    import led_ctrl_pkg::*;
    localparam logic [6:0] TGT_ADDR = 7'h15; // arbitrary value
    localparam int D0 = 40;
    localparam int D1 = 20;
    localparam int D2 = 10;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hw_enable_reset_pin = 1'b0;
    logic pwm_in = 1'b0;
    logic [7:0] headroom_low = 8'h00;
    logic [7:0] als_level = 8'h00;
    logic scl, pull_low, sda_out, sda_oe, int_out, int_oe, pump_gain_high, bus_busy, k;
    logic [7:0] sink_on, als_bright, b;
    logic [2:0] als_zone;
    power_mode_e power_mode;
    wire logic sda = !(pull_low || sda_oe); // pull-up unless pulled low
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    int sink_en, cfg, last_wr, zone_m, irq, dly;
    int trips[4];
    int brights[5];
    logic [31:0] rnd = 32'he7ac;
    led_serial_ctrl #(.DEV_ADDR(TGT_ADDR), .DLY0(D0), .DLY1(D1), .DLY2(D2)) i_led_serial_ctrl (
        .clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .hw_enable_reset_pin(hw_enable_reset_pin), .pwm_in(pwm_in), .headroom_low(headroom_low),
        .als_level(als_level), .int_out(int_out), .int_oe(int_oe), .sink_on(sink_on),
        .pump_gain_high(pump_gain_high), .power_mode(power_mode), .bus_busy(bus_busy),
        .als_zone(als_zone), .als_bright(als_bright));
    bus_host_model i_host (.sda(sda), .scl(scl), .pull_low(pull_low));
    // core clock and hang guard
    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            fails++;
            results();
        end
    end
    function automatic logic [31:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction
    task automatic defaults();
        sink_en = 0;
        cfg = 0;
        irq = 0;
        zone_m = 0;
        trips = '{8'h33, 8'h66, 8'h99, 8'hCC};
        brights = '{8'h99, 8'hB6, 8'hCC, 8'hE6, 8'hFF};
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask
    // settle, then compare outputs with the model
    task automatic state();
        int z;
        logic [7:0] s;
        repeat (12) @(negedge clk);
        z = 0;
        for (int i = 0; i < 4; i++) begin
            z += (trips[i] < als_level);
        end
        irq = irq | (z != zone_m);
        zone_m = z;
        s = (cfg[0] && !(pwm_in ^ cfg[1])) ? 8'h00 : 8'(sink_en);
        chk("sink_on", s, sink_on);
        chk("power_mode", sink_en ? MODE_ACTIVE : MODE_STANDBY, power_mode);
        chk("als_zone", z, als_zone);
        chk("als_bright", brights[z], als_bright);
        chk("int_oe", irq, int_oe);
    endtask
    // whole write transfer; ok says whether the device should answer
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ok);
        i_host.start();
        chk("bus_busy", ok, bus_busy);
        i_host.send_byte({TGT_ADDR, 1'b0}, k);
        chk("addr ack", ok, k);
        i_host.send_byte(a, k);
        chk("reg ack", ok, k);
        i_host.send_byte(d, k);
        chk("data ack", ok, k);
        i_host.stop();
        chk("bus_busy", 1'b0, bus_busy);
        if (ok) begin
            irq = 0;
            last_wr = d;
            case (a)
                ADDR_SINK_EN: sink_en = d;
                ADDR_CONFIG: cfg = d;
                ADDR_OPTIONS: irq = 0;
                default: trips[a[1:0]] = d;
            endcase
            state();
        end
    endtask
    task automatic dip(input logic [7:0] m, input int n);
        @(negedge clk);
        headroom_low = m;
        repeat (n) @(negedge clk);
        headroom_low = 8'h00;
        repeat (8) @(negedge clk);
    endtask
    task automatic results();
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        defaults();
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        hw_enable_reset_pin = 1'b1;
        state();
        chk("gain", 1'b0, pump_gain_high);
        i_host.start();
        i_host.send_byte({TGT_ADDR ^ 7'h01, 1'b0}, k);
        chk("foreign ack", 1'b0, k);
        i_host.send_byte(ADDR_SINK_EN, k);
        chk("ignored ack", 1'b0, k);
        i_host.stop();
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_SINK_EN, i == 1 ? 8'h00 : 8'(xs()) | 8'h01, 1'b1);
        end
        for (int c = 0; c < 5; c++) begin
            wr(ADDR_CONFIG, c < 4 ? {6'h00, c[1], 1'b1} : 8'h00, 1'b1);
            @(negedge clk);
            pwm_in = c[0];
            repeat (3750) @(negedge clk);
            state();
        end
        wr(ADDR_SINK_EN, 8'hA5, 1'b1);
        i_host.start();
        i_host.send_byte({TGT_ADDR, 1'b1}, k);
        chk("read ack", 1'b1, k);
        i_host.read_byte(b, k);
        chk("read data", last_wr, b);
        chk("read slot", 1'b0, k);
        i_host.stop();
        i_host.start();
        i_host.send_byte({TGT_ADDR, 1'b0}, k);
        i_host.send_byte(ADDR_CONFIG, k);
        wr(ADDR_SINK_EN, 8'hF0, 1'b1);
        for (int c = 0; c < 3; c++) begin
            dly = c == 0 ? D0 : c == 1 ? D1 : D2;
            wr(ADDR_OPTIONS, 8'(c), 1'b1);
            dip(8'h01, dly + 20);
            chk("gain", 1'b0, pump_gain_high);
            dip(8'h10, dly / 2);
            chk("gain", 1'b0, pump_gain_high);
            dip(8'h10, dly + 20);
            chk("gain", 1'b1, pump_gain_high);
            wr(ADDR_SINK_EN, 8'hF0, 1'b1);
            chk("gain", 1'b0, pump_gain_high);
        end
        for (int i = 0; i < 7; i++) begin
            @(negedge clk);
            als_level = 8'(i < 4 ? trips[i] + i % 2 : i == 6 ? 0 : xs());
            state();
        end
        wr(8'h61, 8'(xs()), 1'b1);
        @(negedge clk);
        hw_enable_reset_pin = 1'b0;
        repeat (10) @(negedge clk);
        chk("shutdown", MODE_SHUTDOWN, power_mode);
        chk("sinks off", 8'h00, sink_on);
        wr(ADDR_SINK_EN, 8'hFF, 1'b0);
        hw_enable_reset_pin = 1'b1;
        defaults();
        state();
        results();
    end
endmodule
